// ### hdl/ssd_pkg.sv
// Constants shared by the serial status and data buffer block.
// Assumes one bus clock of 250 MHz and a byte-wide register port.
package ssd_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_FLAGS = 3'h0; // serial_flags, read only
  localparam logic [2:0] OFS_DATA = 3'h1; // serial_data_port
  localparam logic [2:0] OFS_CTRL = 3'h2; // control_one
  localparam logic [2:0] OFS_EVT = 3'h3; // sticky events, read clears
  localparam logic [2:0] OFS_MASK = 3'h4; // event mask

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_RXF = 7; // receive_full_flag
  localparam int BIT_TXE = 5; // transmit_empty_flag
  localparam int BIT_MODE_FAULT_FLAG = 4; // mode_fault_flag
  localparam int CTL_RIE = 7; // receive_irq_enable
  localparam int CTL_TIE = 5; // transmit_empty_irq_enable
  localparam int CTL_CONTROLLER_SELECT = 4; // controller_select
  localparam int CTL_FDE = 2; // fault_detect_enable
  localparam int CTL_SOE = 1; // select_output_enable
  localparam int EVT_RX = 0; // byte received
  localparam int EVT_TX = 1; // transmit buffer freed
  localparam int EVT_MODE_FAULT_FLAG = 2; // mode fault seen
  localparam int EVT_W = 3; // event register width

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_TXE = 1'b1; // buffer empty after reset
  localparam logic [7:0] RST_BYTE = 8'h00; // receive and transmit buffers
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0; // events and mask

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 4; // bus clock period
  localparam int HALF_NS = 64; // master serial clock half period
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIV_W = 5; // divider counter width
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);
  localparam logic [3:0] LAST_BIT = 4'h7; // eighth bit index
  localparam int TXE_REARM_CYC = 2; // idle write to flag set again

endpackage

// ### hdl/ssd_sync.sv
// Two flip-flop synchroniser for pins from outside the bus clock.
// Assumes inputs change freely with respect to clock.
`timescale 1ns/1ns
module ssd_sync #(
  parameter int W = 4
) (
  clock,
  rst_n,
  d,
  q
);
  input wire logic clock;
  input wire logic rst_n;
  input wire logic [W-1:0] d;
  output logic [W-1:0] q;

  // First and second stage
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } ssd_sync_t;

  ssd_sync_t s;
  ssd_sync_t next_s;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s.first = d;
    next_s.second = s.first;
  end

  // Stages clear to a constant on reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.second;

endmodule // ssd_sync

// ### hdl/ssd_shifter.sv
// Eight-bit serial shifter, clock mode idle low, sample on rising edge.
// Assumes sck_in, ss_n_in and sdi already synchronised to clock.
`timescale 1ns/1ns
module ssd_shifter
  import ssd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic master,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic sdi,
  output logic busy,
  output logic done,
  output logic [7:0] rx_data,
  output logic sck_out,
  output logic sdo
);

  // Shifter state
  typedef struct packed {
    logic busy;
    logic done;
    logic sck;
    logic sck_d;
    logic smp;
    logic [DIV_W-1:0] div;
    logic [3:0] cnt;
    logic [7:0] sh;
  } ssd_shf_t;

  ssd_shf_t s;
  ssd_shf_t next_s;

  // ----------------------------------------------------------------
  // Edge finding and shifting
  // ----------------------------------------------------------------
  always_comb begin
    logic tick;
    logic rise;
    logic fall;
    logic act;
    tick = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    act = 1'b0;
    next_s = s;
    next_s.done = 1'b0;
    next_s.sck_d = sck_in;
    if (master) begin
      // Divider counts all the time, but ticks only during a transfer
      act = s.busy;
      tick = s.busy && (s.div == DIV_LAST);
      next_s.div = tick ? '0 : s.div + 1'b1;
      if (tick) begin
        next_s.sck = ~s.sck;
      end
      rise = tick && !s.sck;
      fall = tick && s.sck;
    end else begin
      // Slave follows the sampled link clock while selected
      act = !ss_n_in;
      rise = act && sck_in && !s.sck_d;
      fall = act && !sck_in && s.sck_d;
      next_s.sck = 1'b0;
      if (ss_n_in) begin
        next_s.cnt = '0;
      end
    end
    // Sample the incoming bit
    if (rise) begin
      next_s.smp = sdi;
    end
    // Shift and count bits
    if (fall && act) begin
      next_s.sh = {s.sh[6:0], s.smp};
      next_s.cnt = s.cnt + 1'b1;
      if (s.cnt == LAST_BIT) begin
        next_s.cnt = '0;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
    // New byte from the transmit buffer
    if (load && !s.busy) begin
      next_s.sh = load_data;
      next_s.busy = 1'b1;
      next_s.div = '0;
      next_s.cnt = '0;
      next_s.sck = 1'b0;
    end
  end

  // Register the state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;
  assign rx_data = s.sh;
  assign sck_out = s.sck;
  assign sdo = s.sh[7];

endmodule // ssd_shifter

// ### hdl/ssd_top.sv
// Status flags and double-buffered data port of a serial interface.
// Assumes a byte register port on the bus clock and unsynchronised pins.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns

module ssd_top
  import ssd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  output logic tx_irq_req,
  output logic rx_irq_req,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rxf; // receive_full_flag
    logic txe; // transmit_empty_flag
    logic mode_fault_flag; // mode_fault_flag
    logic see_rxf; // status read saw receive full
    logic see_txe; // status read saw transmit empty
    logic see_mode_fault_flag; // status read saw mode fault
    logic [7:0] rx_buf; // receive buffer
    logic [7:0] tx_buf; // transmit buffer
    logic tx_full; // byte waiting in transmit buffer
    logic rie; // receive_irq_enable
    logic tie; // transmit_empty_irq_enable
    logic controller_select; // controller_select
    logic fde; // fault_detect_enable
    logic soe; // select_output_enable
    logic [EVT_W-1:0] evt; // sticky events
    logic [EVT_W-1:0] msk; // event mask
    logic [7:0] rdata; // read data
    logic irq; // masked event output
    logic tx_irq; // transmit request
    logic rx_irq; // receive and fault request
    logic sck_o; // pin drive values
    logic mosi_o;
    logic miso_o;
    logic ss_o;
    logic sck_oe_n; // pin enables, low drives
    logic mosi_oe_n;
    logic miso_oe_n;
    logic ss_oe_n;
  } ssd_state_t;

  ssd_state_t s;
  ssd_state_t next_s;

  // Synchronised pins
  logic [3:0] pin_q;
  logic sck_q;
  logic ss_n_q;
  logic mosi_q;
  logic miso_q;

  // Shifter side
  logic sh_busy;
  logic sh_done;
  logic [7:0] sh_rx;
  logic sh_sck;
  logic sh_sdo;
  logic ld;

  // Bus decode
  logic flags_rd;
  logic data_rd;
  logic data_wr;
  logic ctrl_wr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Strobe qualified by an offset
  function automatic logic hit(input logic stb, input logic [2:0] a,
                               input logic [2:0] ofs);
    hit = stb && (a == ofs);
  endfunction

  // Status word, unused bits zero
  function automatic logic [7:0] flags_word(input logic rxf,
                                            input logic txe,
                                            input logic mode_fault_flag);
    logic [7:0] w;
    w = '0;
    w[BIT_RXF] = rxf;
    w[BIT_TXE] = txe;
    w[BIT_MODE_FAULT_FLAG] = mode_fault_flag;
    flags_word = w;
  endfunction

  assign flags_rd = hit(rd, addr, OFS_FLAGS);
  assign data_rd = hit(rd, addr, OFS_DATA);
  assign data_wr = hit(wr, addr, OFS_DATA);
  assign ctrl_wr = hit(wr, addr, OFS_CTRL);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ssd_sync #(
    .W(4)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({sck_i, ss_n_i, mosi_i, miso_i}),
    .q(pin_q)
  );

  assign sck_q = pin_q[3];
  assign ss_n_q = pin_q[2];
  assign mosi_q = pin_q[1];
  assign miso_q = pin_q[0];

  // queued byte moves
  // Load the shifter whenever a byte waits and it is free
  assign ld = s.tx_full && !sh_busy;

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  ssd_shifter u_shf (
    .clock(clock),
    .rst_n(rst_n),
    .master(s.controller_select),
    .load(ld),
    .load_data(s.tx_buf),
    .sck_in(sck_q),
    .ss_n_in(ss_n_q),
    .sdi(s.controller_select ? miso_q : mosi_q),
    .busy(sh_busy),
    .done(sh_done),
    .rx_data(sh_rx),
    .sck_out(sh_sck),
    .sdo(sh_sdo)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rx_clr;
    logic [EVT_W-1:0] ev_set;
    rx_clr = 1'b0;
    ev_set = '0;
    next_s = s;

    // Status read arms the clear sequences
    if (flags_rd) begin
      next_s.see_rxf = s.rxf;
      next_s.see_txe = s.txe;
      next_s.see_mode_fault_flag = s.mode_fault_flag;
    end

    if (data_rd && s.see_rxf && s.rxf) begin
      rx_clr = 1'b1;
      next_s.rxf = 1'b0;
      next_s.see_rxf = 1'b0;
    end

    if (sh_done) begin
      if (!s.rxf || rx_clr) begin
        next_s.rx_buf = sh_rx;
        next_s.rxf = 1'b1;
        ev_set[EVT_RX] = 1'b1;
      end
      // otherwise overrun: old byte kept silently
    end

    if (data_wr && s.see_txe && s.txe) begin
      next_s.tx_buf = wdata;
      next_s.tx_full = 1'b1;
      next_s.txe = 1'b0;
      next_s.see_txe = 1'b0;
    end

    if (ld) begin
      next_s.tx_full = 1'b0;
      next_s.txe = 1'b1;
      ev_set[EVT_TX] = 1'b1;
    end

    if (ctrl_wr) begin
      next_s.rie = wdata[CTL_RIE];
      next_s.tie = wdata[CTL_TIE];
      next_s.controller_select = wdata[CTL_CONTROLLER_SELECT];
      next_s.fde = wdata[CTL_FDE];
      next_s.soe = wdata[CTL_SOE];
      if (s.see_mode_fault_flag && s.mode_fault_flag) begin
        next_s.mode_fault_flag = 1'b0;
        next_s.see_mode_fault_flag = 1'b0;
      end
    end

    // fault input only in one setting
    if (s.controller_select && s.fde && !s.soe) begin
      if (!ss_n_q) begin
        next_s.mode_fault_flag = 1'b1;
        ev_set[EVT_MODE_FAULT_FLAG] = !s.mode_fault_flag;
      end
    end

    // Mask register
    if (hit(wr, addr, OFS_MASK)) begin
      next_s.msk = wdata[EVT_W-1:0];
    end

    // Event register: read clears, new events win
    if (hit(rd, addr, OFS_EVT)) begin
      next_s.evt = ev_set;
    end else begin
      next_s.evt = s.evt | ev_set;
    end

    // read mux, data one cycle later
    next_s.rdata = '0;
    if (rd) begin
      case (addr)
        OFS_FLAGS: next_s.rdata = flags_word(s.rxf, s.txe, s.mode_fault_flag);
        OFS_DATA: next_s.rdata = s.rx_buf;
        OFS_CTRL: begin
          next_s.rdata[CTL_RIE] = s.rie;
          next_s.rdata[CTL_TIE] = s.tie;
          next_s.rdata[CTL_CONTROLLER_SELECT] = s.controller_select;
          next_s.rdata[CTL_FDE] = s.fde;
          next_s.rdata[CTL_SOE] = s.soe;
        end
        OFS_EVT: next_s.rdata[EVT_W-1:0] = s.evt;
        OFS_MASK: next_s.rdata[EVT_W-1:0] = s.msk;
        default: next_s.rdata = '0;
      endcase
    end

    // Interrupt outputs follow the next flag values
    next_s.irq = |(next_s.evt & next_s.msk);
    next_s.tx_irq = next_s.txe && next_s.tie;
    next_s.rx_irq = (next_s.rxf || next_s.mode_fault_flag) && next_s.rie;

    // Pin drive: master owns clock and data out
    next_s.sck_o = sh_sck;
    next_s.mosi_o = sh_sdo;
    next_s.miso_o = sh_sdo;
    next_s.sck_oe_n = !s.controller_select;
    next_s.mosi_oe_n = !s.controller_select;
    // Slave drives its output only while selected
    next_s.miso_oe_n = s.controller_select || ss_n_q;
    // Automatic select output, low during a transfer
    next_s.ss_o = !sh_busy;
    next_s.ss_oe_n = !(s.controller_select && s.fde && s.soe);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.txe <= RST_TXE;
      s.rx_buf <= RST_BYTE;
      s.tx_buf <= RST_BYTE;
      s.evt <= RST_EVT;
      s.msk <= RST_EVT;
      s.ss_o <= 1'b1;
      s.sck_oe_n <= 1'b1;
      s.mosi_oe_n <= 1'b1;
      s.miso_oe_n <= 1'b1;
      s.ss_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign irq = s.irq;
  assign tx_irq_req = s.tx_irq;
  assign rx_irq_req = s.rx_irq;
  assign sck_o = s.sck_o;
  assign sck_oe_n = s.sck_oe_n;
  assign mosi_o = s.mosi_o;
  assign mosi_oe_n = s.mosi_oe_n;
  assign miso_o = s.miso_o;
  assign miso_oe_n = s.miso_oe_n;
  assign ss_n_o = s.ss_o;
  assign ss_n_oe_n = s.ss_oe_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  rxf_set_a: assert property (sh_done && !s.rxf |=> s.rxf && s.rx_buf == $past(sh_rx))
    else $error("receive flag not set after transfer");

  rxf_clr_a: assert property ($fell(s.rxf) |-> $past(data_rd && s.see_rxf))
    else $error("receive flag cleared without sequence");

  txe_clr_a: assert property ($fell(s.txe) |-> $past(data_wr && s.see_txe))
    else $error("transmit flag cleared without sequence");

  wr_ignore_a: assert property (data_wr && !(s.see_txe && s.txe) && !ld
                                |=> $stable(s.tx_buf) && $stable(s.tx_full))
    else $error("unarmed data write was taken");

  tx_req_a: assert property ($rose(s.txe) && s.tie |-> tx_irq_req)
    else $error("transmit request missing");

  txe_rearm_a: assert property (data_wr && s.see_txe && s.txe && !s.tx_full && !sh_busy
                                |=> !s.txe ##1 s.txe && sh_busy)
    else $error("transmit flag not back in two cycles");

  mode_fault_flag_gate_a: assert property ($rose(s.mode_fault_flag)
                                |-> $past(s.controller_select && s.fde && !s.soe && !ss_n_q))
    else $error("mode fault set in wrong configuration");

  mode_fault_flag_clr_a: assert property ($fell(s.mode_fault_flag) |-> $past(ctrl_wr && s.see_mode_fault_flag))
    else $error("mode fault cleared without sequence");

  data_rd_a: assert property (data_rd |=> rdata == $past(s.rx_buf))
    else $error("data read returned wrong byte");

  overrun_a: assert property (sh_done && s.rxf && !(data_rd && s.see_rxf)
                              |=> $stable(s.rx_buf) && s.rxf)
    else $error("overrun replaced unread byte");

  // Main scenarios
  rx_cov_c: cover property (sh_done && !s.rxf);
  ovr_cov_c: cover property (sh_done && s.rxf);
  mode_fault_flag_cov_c: cover property ($rose(s.mode_fault_flag));
  queue_cov_c: cover property (s.tx_full && sh_busy);

endmodule // ssd_top

// ### bench/ssd_peer.sv
// Far side of the serial link: a slave answering the block as master,
// and a master task that drives the block as slave.
// Assumes the bench resolves every pin and pulls released lines high.
`timescale 1ns/1ns
module ssd_peer (
  sck,
  mosi,
  miso,
  slave_en,
  sck_d,
  mosi_d,
  miso_d,
  ss_n_d,
  rx_byte,
  nbytes
);
  input wire logic sck; // Resolved serial clock
  input wire logic mosi; // Resolved master data
  input wire logic miso; // Resolved slave data
  input wire logic slave_en; // Answer as slave
  output logic sck_d; // Clock while acting as master
  output logic mosi_d; // Data while acting as master
  output logic miso_d; // Data while acting as slave
  output logic ss_n_d; // Select while acting as master
  output logic [7:0] rx_byte; // Last byte taken from the block
  output logic [7:0] nbytes; // Bytes taken as slave
  logic [7:0] tx_sh; // Slave shift-out register
  logic [7:0] rx_sh; // Slave shift-in register
  logic [7:0] resp; // Current answer byte
  int cnt; // Rising edges in this byte

  // Idle link: clock low, select high
  initial begin
    resp = 8'h3C;
    tx_sh = 8'h3C;
    rx_sh = 8'h00;
    rx_byte = 8'h00;
    nbytes = 8'h00;
    cnt = 0;
    sck_d = 1'b0;
    mosi_d = 1'b0;
    ss_n_d = 1'b1;
  end

  // Slave output is always the top of the shifter
  assign miso_d = tx_sh[7];

  // Sample on the rising clock edge, MSB first
  always @(posedge sck) begin
    if (slave_en) begin
      rx_sh = {rx_sh[6:0], mosi};
      cnt++;
    end
  end

  // Shift on the falling edge; after the eighth load the next answer
  always @(negedge sck) begin
    if (slave_en && cnt == 8) begin
      cnt = 0;
      rx_byte = rx_sh;
      nbytes = nbytes + 8'h01;
      resp = resp + 8'h11;
      tx_sh = resp;
    end else if (slave_en) begin
      tx_sh = {tx_sh[6:0], ~tx_sh[0]};
    end
  end

  // One byte as master, 125 ns clock, data changes on the falling edge
  task automatic send(input logic [7:0] b);
    logic [7:0] sh;
    logic [7:0] got;
    sh = b;
    got = 8'h00;
    #7;
    ss_n_d = 1'b0;
    mosi_d = sh[7];
    #63;
    for (int i = 0; i < 8; i++) begin
      sck_d = 1'b1;
      got = {got[6:0], miso};
      #62;
      sck_d = 1'b0;
      sh = {sh[6:0], 1'b0};
      mosi_d = sh[7];
      #63;
    end
    ss_n_d = 1'b1;
    mosi_d = ~mosi_d;
    rx_byte = got;
  endtask
endmodule // ssd_peer

// ### bench/test_spi_status_and_data_buffer.sv
// Self-checking bench for the serial flags and data port.
// Assumes pins pulled high when released and a 250 MHz bus clock.
`timescale 1ns/1ns
module test_spi_status_and_data_buffer;
  import ssd_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] F_RXF = 8'h01 << BIT_RXF;
  localparam logic [7:0] F_TXE = 8'h01 << BIT_TXE;
  localparam logic [7:0] F_MODE_FAULT_FLAG = 8'h01 << BIT_MODE_FAULT_FLAG;
  localparam logic [7:0] C_RIE = 8'h01 << CTL_RIE;
  localparam logic [7:0] C_TIE = 8'h01 << CTL_TIE;
  localparam logic [7:0] C_CONTROLLER_SELECT = 8'h01 << CTL_CONTROLLER_SELECT;
  localparam logic [7:0] C_FDE = 8'h01 << CTL_FDE;
  localparam logic [7:0] C_SOE = 8'h01 << CTL_SOE;
  logic clock, rst_n, wr, rd, slave_en, fault_n;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, p_rx, p_n;
  logic irq, tx_irq_req, rx_irq_req, sck_o, sck_oe_n, mosi_o, mosi_oe_n;
  logic miso_o, miso_oe_n, ss_n_o, ss_n_oe_n, p_sck, p_mosi, p_miso, p_ss_n;
  wire sck_w, mosi_w, miso_w, ss_w; // Resolved pins
  int error_cnt, checks;

  // Pin resolution, released lines pulled high
  assign sck_w = !sck_oe_n ? sck_o : p_sck;
  assign mosi_w = !mosi_oe_n ? mosi_o : p_mosi;
  assign miso_w = !miso_oe_n ? miso_o : (slave_en ? p_miso : 1'b1);
  assign ss_w = !ss_n_oe_n ? ss_n_o : (p_ss_n & fault_n);

  ssd_top i_ssd_top (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_n(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
    .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe_n(ss_n_oe_n));
  ssd_peer i_ssd_peer (.sck(sck_w), .mosi(mosi_w), .miso(miso_w), .slave_en(slave_en),
    .sck_d(p_sck), .mosi_d(p_mosi), .miso_d(p_miso), .ss_n_d(p_ss_n), .rx_byte(p_rx),
    .nbytes(p_n));

  // Bus clock
  always #(CLK_NS / 2) clock = ~clock;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // Let registered outputs follow
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  // Bounded wait for the interrupt line
  task automatic wait_irq;
    for (int n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clock);
    #1;
  endtask
  // Verdict
  task automatic end_sim;
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset state, read-only flags, unmapped offset
  task automatic t_reset;
    rd_chk(OFS_FLAGS, F_TXE);
    chk({5'h00, irq, tx_irq_req, rx_irq_req}, 8'h00);
    wr_reg(OFS_FLAGS, 8'hFF);
    rd_chk(OFS_FLAGS, F_TXE);
    rd_chk(3'h7, 8'h00);
  endtask
  // Master sends one byte; receive flag needs status then data read
  task automatic t_master;
    wr_reg(OFS_MASK, 8'h01);
    wr_reg(OFS_CTRL, C_CONTROLLER_SELECT | C_RIE | C_TIE);
    settle;
    chk({7'h00, tx_irq_req}, 8'h01);
    rd_chk(OFS_FLAGS, F_TXE);
    wr_reg(OFS_DATA, 8'hA5);
    rd_chk(OFS_FLAGS, F_TXE);
    wait_irq;
    chk({7'h00, rx_irq_req}, 8'h01);
    chk(p_rx, 8'hA5);
    rd_chk(OFS_DATA, 8'h3C);
    rd_chk(OFS_FLAGS, F_RXF | F_TXE);
    rd_chk(OFS_DATA, 8'h3C);
    rd_chk(OFS_FLAGS, F_TXE);
    rd_chk(OFS_EVT, 8'h03);
    settle;
    chk({7'h00, irq}, 8'h00);
  endtask
  // Two queued bytes, an ignored third, unread first byte kept
  task automatic t_queue;
    rd_chk(OFS_FLAGS, F_TXE);
    wr_reg(OFS_DATA, 8'h81);
    rd_chk(OFS_FLAGS, F_TXE);
    wr_reg(OFS_DATA, 8'h42);
    rd_chk(OFS_FLAGS, 8'h00);
    chk({7'h00, tx_irq_req}, 8'h00);
    wr_reg(OFS_DATA, 8'hE7);
    wait_irq;
    rd_chk(OFS_FLAGS, F_RXF | F_TXE);
    rd_chk(OFS_EVT, 8'h03);
    // Overrun raises no event, so wait out the second byte
    repeat (300) @(posedge clock);
    chk(p_rx, 8'h42);
    chk(p_n, 8'h03);
    rd_chk(OFS_DATA, 8'h4D);
    rd_chk(OFS_FLAGS, F_TXE);
    rd_chk(OFS_EVT, 8'h00);
  endtask
  // Select low in four configurations; only one may flag a fault
  task automatic t_fault;
    logic [7:0] cfg [3];
    cfg = '{C_CONTROLLER_SELECT | C_RIE, C_FDE | C_RIE, C_CONTROLLER_SELECT | C_FDE | C_SOE | C_RIE};
    @(posedge clock);
    fault_n <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr_reg(OFS_CTRL, cfg[i]);
      repeat (8) @(posedge clock);
      rd_chk(OFS_FLAGS, F_TXE);
    end
    wr_reg(OFS_CTRL, C_CONTROLLER_SELECT | C_FDE | C_RIE);
    repeat (8) @(posedge clock);
    fault_n <= 1'b1;
    #1;
    chk({7'h00, rx_irq_req}, 8'h01);
    wr_reg(OFS_CTRL, C_CONTROLLER_SELECT | C_FDE | C_RIE);
    rd_chk(OFS_FLAGS, F_TXE | F_MODE_FAULT_FLAG);
    wr_reg(OFS_CTRL, C_CONTROLLER_SELECT | C_FDE | C_RIE);
    rd_chk(OFS_FLAGS, F_TXE);
    rd_chk(OFS_EVT, 8'h04);
  endtask
  // Block as slave: byte in from the peer, queued byte out
  task automatic t_slave;
    wr_reg(OFS_CTRL, C_RIE);
    slave_en <= 1'b0;
    rd_chk(OFS_FLAGS, F_TXE);
    wr_reg(OFS_DATA, 8'hC3);
    i_ssd_peer.send(8'h96);
    wait_irq;
    chk(p_rx, 8'hC3);
    wr_reg(OFS_MASK, 8'h00);
    settle;
    chk({7'h00, irq}, 8'h00);
    wr_reg(OFS_MASK, 8'h01);
    settle;
    chk({7'h00, irq}, 8'h01);
    rd_chk(OFS_FLAGS, F_RXF | F_TXE);
    rd_chk(OFS_DATA, 8'h96);
    rd_chk(OFS_EVT, 8'h03);
    settle;
    chk({7'h00, irq}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    slave_en = 1'b1;
    fault_n = 1'b1;
    error_cnt = 0;
    checks = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_master;
    t_queue;
    t_fault;
    t_slave;
    end_sim;
  end
  // Cut a hang short
  initial begin
    #200000;
    error_cnt++;
    end_sim;
  end
endmodule // test_spi_status_and_data_buffer
